/* hw/srp_defs.svh */
// constants for the serial register port: offsets, fields, resets, timing
// assumes a 20 MHz system clock on both ends of the link
// Behaviour
// - instruction byte on first eight rising edges
// - select high then low restarts instruction phase
// - cut-off byte is never committed
// - instruction bits 6:5 give one to four bytes
// - register updates on final bit of byte
// - instruction bit 7 high means read
// - bits 4:0 start address, device steps rest
// - serial clock at most 15 MHz
// - sample on rising, launch on falling edges
// - outputs released while select is high
// - controller holds select low whole cycle
// - config bit 7 makes data pin bidirectional
// - bidirectional mode keeps serial data out released
// - config bit 6 selects lsb-first, instruction too
// - msb-first starts at top byte, decrements
// - lsb-first starts at bottom byte, increments
// - address wraps between 1Fh and 00h
// - format change applies to remaining bytes
// - soft reset clears others, keeps config register
// - controller uses single bytes for config changes
// - data pin always accepts written bits
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH
`define SRP_CFG_ADDR 5'h00
`define SRP_CFG_BIDIR_BIT 7
`define SRP_CFG_LSB_BIT 6
`define SRP_CFG_SRST_BIT 5
`define SRP_CFG_RESET 8'h00
`define SRP_REG_DEFAULT 8'h00
`define SRP_INSTR_RW_BIT 7
`define SRP_INSTR_LEN_HI 6
`define SRP_INSTR_LEN_LO 5
`define SRP_INSTR_ADDR_MSB 4
`define SRP_SYS_HZ 20000000
`define SRP_SCLK_MAX_HZ 15000000
`define SRP_SCLK_HALF_MIN ((`SRP_SYS_HZ + 2 * `SRP_SCLK_MAX_HZ - 1) / (2 * `SRP_SCLK_MAX_HZ))
`define SRP_SCLK_HALF_DEF 4
`endif

/* hw/srp_pkg.sv */
// types and helpers shared by both ends of the serial register port
// assumes srp_defs.svh is on the include path
`default_nettype none
package srp_pkg;
  // device frame position
  typedef enum logic [1:0] {SRP_DEV_INSTR, SRP_DEV_DATA, SRP_DEV_DONE} srp_dev_state_e;
  // controller sequencer
  typedef enum logic [0:0] {SRP_HOST_IDLE, SRP_HOST_RUN} srp_host_state_e;
  typedef logic [7:0] srp_byte_t;
  // bit number idx of a byte as it goes on the wire
  function automatic logic srp_pick(input srp_byte_t b, input logic [2:0] idx,
                                    input logic lsb_first);
    srp_pick = lsb_first ? b[idx] : b[3'd7 - idx];
  endfunction
  // shift one received bit into a partial byte
  function automatic srp_byte_t srp_shift(input srp_byte_t b, input logic bit_in,
                                          input logic lsb_first);
    srp_shift = lsb_first ? {bit_in, b[7:1]} : {b[6:0], bit_in};
  endfunction
endpackage
`default_nettype wire

/* hw/srp_if.sv */
// link wires between controller and device, with the pin resolution
// assumes an idle line floats high (pull-up) when nobody drives it
`default_nettype none
interface srp_if;
  logic serial_clk; // controller-made serial clock
  logic chip_select_n; // active-low frame select
  logic dio_host; // controller drive of the data pin
  logic dio_host_oe_n; // low while controller drives
  logic dio_dev; // device drive of the data pin
  logic dio_dev_oe_n; // low while device drives
  logic serial_data_out; // device drive of the separate out pin
  logic serial_data_out_oe_n; // low while device drives it
  logic dio_line; // resolved data pin
  logic serial_data_out_line; // resolved out pin
  // controller wins a clash; pull-up otherwise
  assign dio_line = !dio_host_oe_n ? dio_host : (!dio_dev_oe_n ? dio_dev : 1'b1);
  assign serial_data_out_line = !serial_data_out_oe_n ? serial_data_out : 1'b1;
  modport dev(input serial_clk, input chip_select_n, input dio_line,
              output dio_dev, output dio_dev_oe_n,
              output serial_data_out, output serial_data_out_oe_n);
  modport host(output serial_clk, output chip_select_n, output dio_host,
               output dio_host_oe_n, input dio_line, input serial_data_out_line);
endinterface
`default_nettype wire

/* hw/srp_device.sv */
// device end of the serial register port: 32 byte registers behind the link
// assumes link pins are asynchronous to clk_sys_in and far slower than it
// assumes the controller leaves select high three cycles between frames
`include "srp_defs.svh"
`default_nettype none
module srp_device (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  srp_if.dev link,
  input wire logic [4:0] peek_addr_in,
  output logic [7:0] peek_data_out,
  output logic cfg_bidir_out,
  output logic cfg_lsb_first_out
);
  import srp_pkg::*;

  // synchronisers; stage 0 feeds stage 1 only
  logic [2:0] sclk_sync_q; // stage 2 kept for edge finding
  logic [1:0] cs_sync_q;
  logic [1:0] din_sync_q;
  logic sclk_rise; // rising serial edge seen
  logic sclk_fall; // falling serial edge seen
  logic cs_active; // select low, synchronised
  logic din; // synchronised data pin

  // frame state
  // it advances on synchronised serial clock edges and drops back to the instruction while select is high
  srp_dev_state_e state_q;
  logic [2:0] bit_cnt_q; // bit within current byte
  logic [1:0] bytes_left_q; // data bytes still to go, minus one
  logic rd_q; // frame is a read
  logic [4:0] addr_q; // current register address
  srp_byte_t rx_q; // partial received byte
  srp_byte_t tx_q; // byte being sent out
  logic drv_q; // read data is on the pin
  logic out_bit_q; // bit currently launched

  // register file
  srp_byte_t regs_q [0:31];
  srp_byte_t rx_full; // byte completed on this edge
  logic lsb_now; // bit order in force right now
  logic bidir_now; // pin mode in force right now
  logic byte_done; // eighth bit arrives on this edge
  logic step_lsb; // bit order that steps to the next address

  // config bits act the moment their byte lands
  // edges come from stages 1 and 2, never from the first stage
  assign lsb_now = regs_q[`SRP_CFG_ADDR][`SRP_CFG_LSB_BIT];
  assign bidir_now = regs_q[`SRP_CFG_ADDR][`SRP_CFG_BIDIR_BIT];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_active = ~cs_sync_q[1];
  assign din = din_sync_q[1];
  assign rx_full = srp_shift(rx_q, din, lsb_now);
  assign byte_done = sclk_rise & cs_active & (bit_cnt_q == 3'd7);
  // a config write on this byte steers the step with its new order
  assign step_lsb = (!rd_q && addr_q == `SRP_CFG_ADDR) ? rx_full[`SRP_CFG_LSB_BIT] : lsb_now;

  // bring the link pins into the system clock domain
  // two flops per pin, three on the serial clock; the three-cycle lag is small against
  // a serial half period, so no edge is missed
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q <= 2'h3;
      din_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], link.serial_clk};
      cs_sync_q <= {cs_sync_q[0], link.chip_select_n};
      // data pin is read whatever the pin mode
      din_sync_q <= {din_sync_q[0], link.dio_line};
    end
  end

  // bit counter and receive shifter, sampled on rising edges
  // the counter wraps from seven to zero, so the next byte starts itself
  // once the frame is done it freezes and no byte can complete
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
    end else if (!cs_active) begin
      // select high: back to start, partial byte dropped
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
    end else if (sclk_rise && state_q != SRP_DEV_DONE) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_full;
    end
  end

  // frame sequencer: instruction then one to four data bytes
  // only a byte completed with select low advances it, so a cut
  // byte leaves address and length untouched
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= SRP_DEV_INSTR;
      bytes_left_q <= 2'h0;
      rd_q <= 1'b0;
      addr_q <= 5'h00;
    end else if (!cs_active) begin
      state_q <= SRP_DEV_INSTR;
    end else if (byte_done) begin
      unique case (state_q)
        SRP_DEV_INSTR: begin
          // eighth rising edge closes the instruction
          state_q <= SRP_DEV_DATA;
          rd_q <= rx_full[`SRP_INSTR_RW_BIT];
          bytes_left_q <= rx_full[`SRP_INSTR_LEN_HI:`SRP_INSTR_LEN_LO];
          addr_q <= rx_full[`SRP_INSTR_ADDR_MSB:0];
        end
        SRP_DEV_DATA: begin
          // step address; five-bit arithmetic wraps at the ends
          if (step_lsb) begin
            addr_q <= addr_q + 5'h01;
          end else begin
            addr_q <= addr_q - 5'h01;
          end
          if (bytes_left_q == 2'h0) begin
            state_q <= SRP_DEV_DONE;
          end else begin
            bytes_left_q <= bytes_left_q - 2'h1;
          end
        end
        SRP_DEV_DONE: begin
          // extra edges past the frame are ignored
          state_q <= SRP_DEV_DONE;
        end
      endcase
    end
  end

  // register writes land on the last bit of each byte
  // a byte commits whole on its eighth edge or not at all;
  // a cut byte never reaches byte_done
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= `SRP_REG_DEFAULT;
      end
      regs_q[`SRP_CFG_ADDR] <= `SRP_CFG_RESET;
    end else if (byte_done && state_q == SRP_DEV_DATA && !rd_q) begin
      regs_q[addr_q] <= rx_full;
      if (addr_q == `SRP_CFG_ADDR && rx_full[`SRP_CFG_SRST_BIT]) begin
        // soft reset spares the config register itself
        for (int i = 1; i < 32; i++) begin
          regs_q[i] <= `SRP_REG_DEFAULT;
        end
      end
    end
  end

  // read data launched on falling edges
  // each byte is fetched on its first fall, after the address
  // step of the byte before has settled
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drv_q <= 1'b0;
      out_bit_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (!cs_active) begin
      drv_q <= 1'b0;
    end else if (sclk_fall && state_q == SRP_DEV_DATA && rd_q) begin
      // first fall after the instruction starts driving
      drv_q <= 1'b1;
      if (bit_cnt_q == 3'h0) begin
        tx_q <= regs_q[addr_q];
        out_bit_q <= srp_pick(regs_q[addr_q], 3'h0, lsb_now);
      end else begin
        out_bit_q <= srp_pick(tx_q, bit_cnt_q, lsb_now);
      end
    end
  end

  // pin drivers; one cycle behind drv_q keeps them on flops
  // the extra cycle is harmless: the host samples late in the
  // high half, several cycles after the pin settles
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.dio_dev <= 1'b0;
      link.dio_dev_oe_n <= 1'b1;
      link.serial_data_out <= 1'b0;
      link.serial_data_out_oe_n <= 1'b1;
    end else begin
      // both pins carry the same bit; the enables pick the live one
      link.dio_dev <= out_bit_q;
      link.serial_data_out <= out_bit_q;
      // release both pins while select is high
      link.dio_dev_oe_n <= ~(drv_q & cs_active & bidir_now);
      link.serial_data_out_oe_n <= ~(drv_q & cs_active & ~bidir_now);
    end
  end

  // user-side view of the register file
  // one cycle of latency; the peek address may change every cycle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      peek_data_out <= 8'h00;
      cfg_bidir_out <= 1'b0;
      cfg_lsb_first_out <= 1'b0;
    end else begin
      peek_data_out <= regs_q[peek_addr_in];
      cfg_bidir_out <= bidir_now;
      cfg_lsb_first_out <= lsb_now;
    end
  end
endmodule
`default_nettype wire

/* hw/srp_host.sv */
// controller end: runs one frame per request and makes the serial clock
// assumes the user mirrors the device's pin mode and bit order on cfg inputs
`include "srp_defs.svh"
`default_nettype none
module srp_host #(
  parameter int unsigned SCLK_HALF = `SRP_SCLK_HALF_DEF // sys cycles per half clock
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  srp_if.host link,
  input wire logic req_valid_in,
  input wire logic req_read_in,
  input wire logic [1:0] req_len_in,
  input wire logic [4:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic cfg_bidir_in,
  input wire logic cfg_lsb_first_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_rdata_out
);
  import srp_pkg::*;

  // half period never below the 15 MHz limit
  localparam int unsigned HALF = (SCLK_HALF < `SRP_SCLK_HALF_MIN) ?
                                 `SRP_SCLK_HALF_MIN : SCLK_HALF;

  srp_host_state_e state_q;
  logic [15:0] div_q; // cycles into the current half period
  logic [5:0] bit_q; // frame bit index, 0..39
  logic [5:0] last_q; // index of the frame's last bit
  logic [39:0] frame_q; // instruction then data bytes, byte 0 first
  logic rd_q;
  logic lsb_q; // bit order latched at the request
  logic bidir_q;
  logic [1:0] dio_sync_q; // data pin synchroniser
  logic [1:0] sdo_sync_q; // out pin synchroniser
  logic din; // read data, picked after both synchronisers
  logic half_end;
  logic [5:0] nxt_bit;

  assign half_end = (div_q == 16'(HALF - 1));
  assign nxt_bit = bit_q + 6'h01;
  // pin choice made after the flops so no logic sees a raw pin
  assign din = bidir_q ? dio_sync_q[1] : sdo_sync_q[1];

  // bring both returning pins in; idle level is the pull-up
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dio_sync_q <= 2'h3;
      sdo_sync_q <= 2'h3;
    end else begin
      dio_sync_q <= {dio_sync_q[0], link.dio_line};
      sdo_sync_q <= {sdo_sync_q[0], link.serial_data_out_line};
    end
  end

  // frame sequencer with clock divider
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= SRP_HOST_IDLE;
      div_q <= 16'h0000;
      bit_q <= 6'h00;
      last_q <= 6'h00;
      frame_q <= 40'h00_0000_0000;
      rd_q <= 1'b0;
      lsb_q <= 1'b0;
      bidir_q <= 1'b0;
      req_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 32'h0000_0000;
      link.serial_clk <= 1'b0;
      link.chip_select_n <= 1'b1;
      link.dio_host <= 1'b0;
      link.dio_host_oe_n <= 1'b1;
    end else begin
      rsp_valid_out <= 1'b0;
      unique case (state_q)
        SRP_HOST_IDLE: begin
          if (req_valid_in) begin
            // select stays low to the last bit
            state_q <= SRP_HOST_RUN;
            req_ready_out <= 1'b0;
            rd_q <= req_read_in;
            lsb_q <= cfg_lsb_first_in;
            bidir_q <= cfg_bidir_in;
            last_q <= 6'({req_len_in, 3'h7}) + 6'h08;
            frame_q <= {req_wdata_in, req_read_in, req_len_in, req_addr_in};
            bit_q <= 6'h00;
            div_q <= 16'h0000;
            rsp_rdata_out <= 32'h0000_0000;
            link.chip_select_n <= 1'b0;
            link.dio_host_oe_n <= 1'b0;
            link.dio_host <= srp_pick({req_read_in, req_len_in, req_addr_in},
                                      3'h0, cfg_lsb_first_in);
          end
        end
        SRP_HOST_RUN: begin
          div_q <= half_end ? 16'h0000 : div_q + 16'h0001;
          if (half_end && !link.serial_clk) begin
            link.serial_clk <= 1'b1; // device samples here
          end else if (half_end) begin
            // late in the high half: take read bit, then fall
            if (rd_q && bit_q >= 6'h08) begin
              rsp_rdata_out[{bit_q[4:3] - 2'h1, 3'h0} + 5'(lsb_q ? bit_q[2:0]
                            : 3'h7 - bit_q[2:0])] <= din;
            end
            link.serial_clk <= 1'b0;
            bit_q <= nxt_bit;
            if (bit_q == last_q) begin
              state_q <= SRP_HOST_IDLE;
              link.chip_select_n <= 1'b1;
              link.dio_host_oe_n <= 1'b1;
              req_ready_out <= 1'b1;
              rsp_valid_out <= 1'b1;
            end else begin
              // launch the next bit on the falling edge
              link.dio_host_oe_n <= rd_q && nxt_bit >= 6'h08;
              link.dio_host <= srp_pick(frame_q[{nxt_bit[5:3], 3'h0} +: 8],
                                        nxt_bit[2:0], lsb_q);
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/srp_link_sva.sv */
// checker on the link wires joining host and device
// assumes both ends share clk_sys_in and arst_n_in
`default_nettype none
module srp_link_sva (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic dio_host,
  input wire logic dio_host_oe_n,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  input wire logic dio_dev_oe_n
);
  logic [5:0] cnt_q; // rising serial edges in this frame
  logic sclk_q; // last serial clock level
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // edge count, cleared while select is high
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_q <= 1'b0;
      cnt_q <= 6'h00;
    end else begin
      sclk_q <= serial_clk;
      if (chip_select_n) begin
        cnt_q <= 6'h00;
      end else if (serial_clk && !sclk_q) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
  a_frame_len: assert property ($rose(chip_select_n) |->
    cnt_q inside {6'h10, 6'h18, 6'h20, 6'h28}) else $error("frame length");
  // count starts at 1 so a late release of the previous frame is allowed
  a_instr_quiet: assert property (!chip_select_n && cnt_q != 6'h00 && cnt_q < 6'h08 |->
    dio_dev_oe_n && serial_data_out_oe_n) else $error("drive in instruction");
  a_release_cs: assert property ($rose(chip_select_n) |->
    ##[1:6] (dio_dev_oe_n && serial_data_out_oe_n)) else $error("no release");
  a_sclk_still: assert property (chip_select_n && $past(chip_select_n) |->
    $stable(serial_clk)) else $error("clock runs idle");
  a_cs_gates: assert property ($rose(serial_clk) |-> !chip_select_n)
    else $error("edge outside frame");
  a_dev_launch: assert property (serial_clk && $past(serial_clk) &&
    !serial_data_out_oe_n && $past(!serial_data_out_oe_n) |-> $stable(serial_data_out))
    else $error("out bit moved high");
  a_host_launch: assert property (serial_clk && $past(serial_clk) &&
    !dio_host_oe_n && $past(!dio_host_oe_n) |-> $stable(dio_host)) else $error("in bit moved");
  a_sdo_bidir: assert property (!dio_dev_oe_n |-> serial_data_out_oe_n)
    else $error("both pins driven");
  c_long: cover property ($rose(chip_select_n) && cnt_q == 6'h28);
  c_sdo_read: cover property (!serial_data_out_oe_n);
  c_dio_read: cover property (!dio_dev_oe_n);
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// bench: host and device on one link, a second device bit-banged
// assumes design files compiled first, default SCLK_HALF
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import srp_pkg::*;
  logic clk_sys_in = 1'b0; // 50 ns clock
  logic arst_n_in = 1'b0; // async reset
  logic rq_v = 1'b0; // request strobe
  logic rq_rd = 1'b0;
  logic [1:0] rq_n = 2'h0;
  logic [4:0] rq_a = 5'h00;
  logic [31:0] rq_d = 32'h0;
  logic h_bidir = 1'b0; // host mirror of pin mode
  logic h_lsb = 1'b0; // host mirror of bit order
  logic rdy, rsp_v, bidir, lsb, early;
  logic [31:0] rsp_d;
  logic [4:0] pk_a = 5'h00; // peek address
  logic [4:0] pk2_a = 5'h03;
  logic [7:0] pk_d, pk2_d;
  srp_byte_t model [32]; // expected register file
  int n_fail = 0;
  int tests_run = 0;
  int seed = 71;
  srp_if link_if ();
  srp_if bad_if (); // rule breaker side
  srp_host srp_host_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .link(link_if),
    .req_valid_in(rq_v), .req_read_in(rq_rd), .req_len_in(rq_n), .req_addr_in(rq_a),
    .req_wdata_in(rq_d), .cfg_bidir_in(h_bidir), .cfg_lsb_first_in(h_lsb),
    .req_ready_out(rdy), .rsp_valid_out(rsp_v), .rsp_rdata_out(rsp_d));
  srp_device srp_device_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .link(link_if), .peek_addr_in(pk_a), .peek_data_out(pk_d), .cfg_bidir_out(bidir),
    .cfg_lsb_first_out(lsb));
  srp_device srp_device_inst_b (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .link(bad_if), .peek_addr_in(pk2_a), .peek_data_out(pk2_d), .cfg_bidir_out(),
    .cfg_lsb_first_out());
  srp_link_sva srp_link_sva_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .serial_clk(link_if.serial_clk), .chip_select_n(link_if.chip_select_n),
    .dio_host(link_if.dio_host), .dio_host_oe_n(link_if.dio_host_oe_n),
    .serial_data_out(link_if.serial_data_out), .dio_dev_oe_n(link_if.dio_dev_oe_n),
    .serial_data_out_oe_n(link_if.serial_data_out_oe_n));
  // free running system clock
  initial forever #25 clk_sys_in = ~clk_sys_in;
  // n edges, then just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // next address the device should use
  function automatic logic [4:0] step(input logic [4:0] a);
    return h_lsb ? a + 5'h01 : a - 5'h01;
  endfunction
  // one host frame; writes update the model, reads are compared
  task automatic xfer(input logic rd, input logic [1:0] n, input logic [4:0] a,
                      input logic [31:0] d);
    int i;
    int k;
    logic [4:0] p;
    early = 1'b0;
    pk_a = a;
    rq_rd = rd;
    rq_n = n;
    rq_a = a;
    rq_d = d;
    rq_v = 1'b1;
    tick(1);
    rq_v = 1'b0;
    check(8'({rdy, link_if.chip_select_n}), 8'h00);
    // first byte must land before the frame ends
    for (i = 0; i < 600 && rsp_v !== 1'b1; i++) begin
      tick(1);
      if (!rd && rsp_v !== 1'b1 && pk_d === d[7:0]) early = 1'b1;
    end
    if (i >= 600) begin
      n_fail++;
      final_report();
    end
    check(8'({rdy, link_if.chip_select_n}), 8'h03);
    p = a;
    for (k = 0; k <= n; k++) begin
      if (rd) check(rsp_d[8*k +: 8], model[p]);
      else model[p] = d[8*k +: 8];
      p = step(p);
    end
    if (!rd && n != 2'h0) check(8'(early), 8'h01);
    tick(2);
  endtask
  // whole register file against the model
  task automatic peek_all();
    for (int a = 0; a < 32; a++) begin
      pk_a = 5'(a);
      tick(1);
      check(pk_d, model[a]);
    end
  endtask
  // random write then read; range keeps clear of the config register
  task automatic rand_run(input int cnt);
    logic [4:0] a;
    logic [31:0] d;
    repeat (cnt) begin
      a = 5'h04 + 5'($unsigned($random(seed)) % 24);
      d = $random(seed);
      d[7:0] = model[a] ^ 8'hA5;
      xfer(1'b0, 2'($random(seed)), a, d);
      xfer(1'b1, 2'($random(seed)), a, 32'h0);
    end
  endtask
  // bit-banged msb-first frame on the second link
  task automatic bang(input int nb, input logic [15:0] v);
    bad_if.chip_select_n = 1'b0;
    bad_if.dio_host_oe_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      bad_if.dio_host = v[i];
      #200 bad_if.serial_clk = 1'b1;
      #200 bad_if.serial_clk = 1'b0;
    end
    #200 bad_if.chip_select_n = 1'b1;
    bad_if.dio_host_oe_n = 1'b1;
    #400;
  endtask
  initial begin
    for (int a = 0; a < 32; a++) model[a] = 8'h00;
    bad_if.serial_clk = 1'b0;
    bad_if.chip_select_n = 1'b1;
    bad_if.dio_host = 1'b0;
    bad_if.dio_host_oe_n = 1'b1;
    tick(10);
    arst_n_in = 1'b1;
    tick(5);
    peek_all();
    check(8'({bidir, lsb}), 8'h00);
    $display("reset values done");
    rand_run(10);
    xfer(1'b0, 2'h2, 5'h01, {8'h00, 8'h33, 8'h00, ~model[1]});
    xfer(1'b1, 2'h2, 5'h01, 32'h0);
    $display("msb first done");
    xfer(1'b0, 2'h0, 5'h00, 32'h40);
    h_lsb = 1'b1;
    check(8'(lsb), 8'h01);
    rand_run(10);
    xfer(1'b0, 2'h3, 5'h1E, {8'h22, 8'h40, 8'h1F, ~model[30]});
    xfer(1'b1, 2'h3, 5'h1E, 32'h0);
    $display("lsb first done");
    xfer(1'b0, 2'h0, 5'h00, 32'hC0);
    h_bidir = 1'b1;
    check(8'(bidir), 8'h01);
    rand_run(6);
    $display("bidir done");
    xfer(1'b0, 2'h0, 5'h00, 32'hE0);
    for (int a = 1; a < 32; a++) model[a] = 8'h00;
    peek_all();
    xfer(1'b0, 2'h0, 5'h00, 32'h00);
    h_lsb = 1'b0;
    h_bidir = 1'b0;
    rand_run(4);
    peek_all();
    $display("soft reset done");
    // stray edges with select high must be ignored
    repeat (3) begin
      #200 bad_if.serial_clk = 1'b1;
      #200 bad_if.serial_clk = 1'b0;
    end
    bang(13, 16'h0075);
    tick(2);
    check(pk2_d, 8'h00);
    bang(16, 16'h033C);
    tick(2);
    check(pk2_d, 8'h3C);
    $display("cut frame done");
    final_report();
  end
endmodule
`default_nettype wire
